// ### design/adc_readout.sv
`timescale 1ns/1ps
module adc_readout
  import adc_readout_pkg::*;
#(
  parameter int DATA_W = RESULT_BITS
)
(
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic              CS_N,
  input  wire logic              SCK,
  input  wire logic [DATA_W-1:0] SAMPLE_CODE,
  output logic                   SERIAL_DATA_OUT_O,
  output logic                   SERIAL_DATA_OUT_OE_N,
  output logic                   TRACKING,
  output logic                   CONV_DONE,
  output logic [DATA_W-1:0]      RESULT
);

  pin_event_type         ev;
  logic                  cs_low;
  frame_state_type       state;
  logic [SLOT_W-1:0]     slot;
  logic [DATA_W-1:0]     trial;
  logic [DATA_W-1:0]     held_code;
  logic [DATA_W-1:0]     frame_bits;

  pin_sync u_pin_sync
  (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .cs_n_pin (CS_N),
    .sck_pin  (SCK),
    .events   (ev),
    .cs_low   (cs_low)
  );

  // frame sequencer
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= ST_IDLE;
      slot  <= SLOT_FIRST;
    end
    else if (ev.cs_rise || !cs_low)
    begin
      state <= ST_IDLE;
      slot  <= SLOT_FIRST;
    end
    else if (ev.cs_fall)
    begin
      state <= ST_SHIFT;
      slot  <= SLOT_FIRST;
    end
    else if (ev.sck_fall && state == ST_SHIFT)
    begin
      slot <= slot + 5'h01;
      if (slot == SLOT_LAST)
      begin
        state <= ST_DONE;
      end
    end
  end

  // sample held at conversion start, refined one bit per shift clock
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      held_code <= '0;
      trial     <= '0;
    end
    else if (ev.cs_fall)
    begin
      held_code <= SAMPLE_CODE;
      trial     <= '0;
    end
    else if (ev.sck_fall && state == ST_SHIFT && slot < SLOT_TRACK - 5'h01)
    begin
      if (slot >= SLOT_MSB)
      begin
        trial[DATA_W - int'(slot)] <= held_code[DATA_W - int'(slot)];
      end
    end
  end

  always_comb
  begin
    frame_bits = trial;
    if (ev.sck_fall && slot >= SLOT_MSB && slot <= SLOT_LSB)
    begin
      frame_bits[DATA_W - int'(slot)] = held_code[DATA_W - int'(slot)];
    end
  end

  // serial output, slot n+1 driven on the fall that leaves slot n
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SERIAL_DATA_OUT_O    <= 1'b0;
      SERIAL_DATA_OUT_OE_N <= 1'b1;
    end
    else if (!cs_low)
    begin
      SERIAL_DATA_OUT_O    <= 1'b0;
      SERIAL_DATA_OUT_OE_N <= 1'b1;
    end
    else if (ev.cs_fall)
    begin
      SERIAL_DATA_OUT_O    <= 1'b0;
      SERIAL_DATA_OUT_OE_N <= 1'b0;
    end
    else if (ev.sck_fall && state == ST_SHIFT)
    begin
      if (slot == SLOT_LAST)
      begin
        SERIAL_DATA_OUT_O    <= 1'b0;
        SERIAL_DATA_OUT_OE_N <= 1'b1;
      end
      else if (slot >= SLOT_MSB && slot <= SLOT_LSB)
      begin
        SERIAL_DATA_OUT_O <= frame_bits[DATA_W - int'(slot)];
      end
      else
      begin
        SERIAL_DATA_OUT_O <= 1'b0;
      end
    end
  end

  // tracking and result status
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      TRACKING  <= 1'b1;
      CONV_DONE <= 1'b0;
      RESULT    <= '0;
    end
    else
    begin
      CONV_DONE <= 1'b0;
      if (ev.cs_fall)
      begin
        TRACKING <= 1'b0;
      end
      else if (ev.sck_fall && state == ST_SHIFT && slot == SLOT_TRACK - 5'h01)
      begin
        TRACKING <= 1'b1;
      end
      else if (ev.cs_rise)
      begin
        TRACKING <= 1'b1;
      end
      if (ev.sck_fall && state == ST_SHIFT && slot == SLOT_TRACK - 5'h02)
      begin
        CONV_DONE <= 1'b1;
        RESULT    <= frame_bits;
      end
    end
  end

  property release_on_cs;
    @(posedge CLK) disable iff (!ARST_N)
    !cs_low |=> SERIAL_DATA_OUT_OE_N;
  endproperty
  release_cs_a : assert property (release_on_cs)
    else $error("output driven while chip select high");

  sequence last_slot_fall;
    ev.sck_fall && state == ST_SHIFT && slot == SLOT_LAST && cs_low;
  endsequence
  release_end_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    last_slot_fall |=> SERIAL_DATA_OUT_OE_N)
    else $error("output not released at frame end");

  start_drive_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    ev.cs_fall |=> !SERIAL_DATA_OUT_OE_N && !SERIAL_DATA_OUT_O && state == ST_SHIFT)
    else $error("frame start not driving leading zero");

  data_on_fall_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    $changed(SERIAL_DATA_OUT_O) && !SERIAL_DATA_OUT_OE_N |-> $past(ev.sck_fall))
    else $error("data changed without shift clock fall");

  msb_first_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    ev.sck_fall && cs_low && state == ST_SHIFT && slot == SLOT_MSB
    |=> SERIAL_DATA_OUT_O == held_code[DATA_W-1])
    else $error("first result bit is not the msb");

  lead_zero_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    ev.sck_fall && cs_low && state == ST_SHIFT && (slot == 5'h00 || slot == 5'h0D || slot == 5'h0E)
    |=> !SERIAL_DATA_OUT_O)
    else $error("padding slot not zero");

  idle_counter_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    !cs_low ##1 !cs_low |-> slot == SLOT_FIRST && state == ST_IDLE)
    else $error("counter moved while chip select high");

  advance_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    ev.sck_fall && cs_low && !ev.cs_fall && state == ST_SHIFT |=> slot == $past(slot) + 5'h01)
    else $error("shift clock fall did not advance slot");

  track_a : assert property (@(posedge CLK) disable iff (!ARST_N)
    ev.sck_fall && cs_low && state == ST_SHIFT && slot == 5'h0D |=> TRACKING)
    else $error("not tracking after fourteenth fall");

endmodule

// ### design/adc_readout_pkg.sv
package adc_readout_pkg;

  localparam int RESULT_BITS  = 12;
  localparam int LEAD_ZEROS   = 2;
  localparam int TRAIL_ZEROS  = 2;
  localparam int FRAME_SLOTS  = LEAD_ZEROS + RESULT_BITS + TRAIL_ZEROS;
  localparam int TRACK_EDGE   = 14;
  localparam int SLOT_W       = 5;

  localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h00;
  localparam logic [SLOT_W-1:0] SLOT_LAST  = 5'h0F;
  localparam logic [SLOT_W-1:0] SLOT_DONE  = 5'h10;
  localparam logic [SLOT_W-1:0] SLOT_TRACK = 5'h0E;
  localparam logic [SLOT_W-1:0] SLOT_MSB   = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_LSB   = 5'h0C;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } frame_state_type;

  typedef struct packed {
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
  } pin_event_type;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import adc_readout_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          cs_n_pin,
  input  wire logic          sck_pin,
  output pin_event_type      events,
  output logic               cs_low
);

  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic       cs_prev;
  logic       sck_prev;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_sync  <= 2'b11;
      sck_sync <= 2'b00;
      cs_prev  <= 1'b1;
      sck_prev <= 1'b0;
    end
    else
    begin
      cs_sync  <= {cs_sync[0], cs_n_pin};
      sck_sync <= {sck_sync[0], sck_pin};
      cs_prev  <= cs_sync[1];
      sck_prev <= sck_sync[1];
    end
  end

  always_comb
  begin
    events.cs_fall  = cs_prev & ~cs_sync[1];
    events.cs_rise  = ~cs_prev & cs_sync[1];
    events.sck_fall = sck_prev & ~sck_sync[1] & ~cs_sync[1];
    cs_low          = ~cs_sync[1];
  end

endmodule

// ### test/host_master.sv
`timescale 1ns/1ps
module host_master
(
  output logic      cs_n,
  output logic      sck,
  input  wire logic sdo_o,
  input  wire logic sdo_oe_n
);
  logic        last = 1'b0;
  logic        lvl;
  logic        rise_v;
  logic        stable;
  logic [15:0] bits;
  logic [16:0] en_n;
  initial cs_n = 1'b1;
  initial sck = 1'b1;
  always @(sdo_o or sdo_oe_n) if (!sdo_oe_n) last = sdo_o;
  // released line shows the inverse of its last driven level
  assign lvl = sdo_oe_n ? ~last : sdo_o;
  task automatic frame(input int n);
    stable = 1'b1;
    en_n = '1;
    cs_n <= 1'b0;
    #125;
    for (int i = 0; i < n; i++)
    begin
      if (i > 0 && lvl !== rise_v) stable = 1'b0;
      bits[15-i] = lvl;
      en_n[i] = sdo_oe_n;
      sck <= 1'b0;
      #62.5;
      rise_v = lvl;
      sck <= 1'b1;
      #62.5;
    end
    en_n[n] = sdo_oe_n;
    cs_n <= 1'b1;
    #125;
  endtask
  // shift clock activity with chip select high
  task automatic wiggle();
    repeat (6)
    begin
      sck <= ~sck;
      #62.5;
    end
  endtask
endmodule

// ### test/adc_readout_tb.sv
`timescale 1ns/1ps
module adc_readout_tb;
  import adc_readout_pkg::*;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic [RESULT_BITS-1:0] code = 12'hfff;
  logic [RESULT_BITS-1:0] exp_c = 12'hfff;
  logic [RESULT_BITS-1:0] exp_r = '0;
  logic [RESULT_BITS-1:0] res;
  logic [31:0]            seed = 32'h73fe_3b86;
  wire logic              cs_n;
  wire logic              sck;
  wire logic              sdo_o;
  wire logic              oe_n;
  wire logic              trk;
  wire logic              done;
  int                     n_done = 0;
  int                     exp_done = 0;
  int                     miscompares = 0;
  int                     n_tests = 0;
  int                     plan [6] = '{16, 6, 16, 16, 16, 14};
  initial forever #5 clk = ~clk;
  adc_readout adc_readout_i (
    .CLK                  (clk),
    .ARST_N               (arst_n),
    .CS_N                 (cs_n),
    .SCK                  (sck),
    .SAMPLE_CODE          (code),
    .SERIAL_DATA_OUT_O    (sdo_o),
    .SERIAL_DATA_OUT_OE_N (oe_n),
    .TRACKING             (trk),
    .CONV_DONE            (done),
    .RESULT               (res)
  );
  host_master host_master_i (
    .cs_n     (cs_n),
    .sck      (sck),
    .sdo_o    (sdo_o),
    .sdo_oe_n (oe_n)
  );
  always @(posedge clk) if (done === 1'b1) n_done <= n_done + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic run(input int n);
    logic [15:0] w;
    w = {2'b00, exp_c, 2'b00};
    fork
      host_master_i.frame(n);
      begin
        repeat (40) @(posedge clk);
        chk("track_low", 16'h0000, 16'(trk));
        seed = xs(seed);
        code <= seed[RESULT_BITS-1:0];
      end
    join
    if (n >= 14) exp_done++;
    if (n >= 14) exp_r = exp_c;
    if (n == 16) chk("data", w, host_master_i.bits);
    if (n == 14) chk("data14", w >> 2, host_master_i.bits >> 2);
    if (n < 14) chk("data_part", w >> (16 - n), host_master_i.bits >> (16 - n));
    if (n == 16) chk("rel", 16'h0001, 16'(host_master_i.en_n[16]));
    chk("oe", '0, host_master_i.en_n[15:0] & ~(16'hffff << n));
    chk("oe_end", 16'h0001, 16'(oe_n));
    chk("stable", 16'h0001, 16'(host_master_i.stable));
    chk("done", 16'(exp_done), 16'(n_done));
    chk("track", 16'h0001, 16'(trk));
    chk("result", 16'(exp_r), 16'(res));
    exp_c = code;
  endtask
  task final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    chk("rst_oe", 16'h0001, 16'(oe_n));
    chk("rst_res", 16'h0000, 16'(res));
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    foreach (plan[k])
    begin
      if (k == 2) host_master_i.wiggle();
      run(plan[k]);
    end
    final_report();
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
